// ---- strobe_latch_pkg.sv ----
package strobe_latch_pkg;

   // System clock and the delay line on its copy
   localparam int CLK_PERIOD_NS    = 40;
   localparam int CLK_DELAY_NS     = 8;
   localparam int CLK_DELAY_CYCLES =
      ((CLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
      (CLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Row strobe copies: four to the array, one to the mux delay line
   localparam int ROW_STROBE_COPIES = 5;
   localparam int ROW_STROBE_MUX    = 4;

   // Chip select copies per bank
   localparam int CS_COPIES = 2;

   // Upper address field held by the flow-through latch
   localparam int ADDR_LO = 13;
   localparam int ADDR_HI = 22;
   localparam int ADDR_W  = ADDR_HI - ADDR_LO + 1;

   // Refresh counter
   localparam int REF_W = 9;
   localparam logic [REF_W-1:0] REF_RESET = 9'h000;

   localparam logic [ROW_STROBE_COPIES-1:0] ROW_STROBE_RESET = 5'h00;
   localparam logic [CS_COPIES-1:0]         CS_RESET         = 2'h0;
   localparam logic [CS_COPIES-1:0]         CS_ALL           = 2'h3;

   // Access kind owning the row strobe, Gray ordered
   typedef enum logic [1:0] {
      kind_idle    = 2'b00,
      kind_instr   = 2'b01,
      kind_data    = 2'b11,
      kind_refresh = 2'b10
   } access_kind_type;

endpackage : strobe_latch_pkg

// ---- addr_hold_latch.sv ----
`timescale 1ns/1ns
module addr_hold_latch (
   input  wire logic                               rst,
   input  wire logic                               latch_en,
   input  wire logic [strobe_latch_pkg::ADDR_W-1:0] addr_in,
   output logic      [strobe_latch_pkg::ADDR_W-1:0] addr_out
);
   import strobe_latch_pkg::*;

   logic [ADDR_W-1:0] la_r;
   logic [ADDR_W-1:0] en_vec;
   logic [ADDR_W-1:0] pass_term;
   logic [ADDR_W-1:0] hold_term;
   logic [ADDR_W-1:0] cover_term;
   logic [ADDR_W-1:0] la_nxt;

   assign en_vec     = {ADDR_W{latch_en}};
   assign pass_term  = en_vec & addr_in;                  // see [R12]
   assign hold_term  = ~en_vec & la_r;                    // see [R12]
   // Consensus term keeps the bit through enable skew
   assign cover_term = addr_in & la_r;                    // see [R13]
   assign la_nxt     = pass_term | cover_term;

   // Transparent while enabled, holds while closed
   always_latch begin
      if (rst) begin
         la_r <= {ADDR_W{1'b0}};
      end else if (latch_en) begin
         la_r <= la_nxt;                                   // see [R12]
      end
   end

   assign addr_out = pass_term | hold_term | cover_term;  // see [R13]

endmodule : addr_hold_latch

// ---- interleaved_dram_strobe_latch_ctrl.sv ----
`timescale 1ns/1ns
// Summary of operation
// [R1] Each bank's write-data latch opens only on alternate cycles.
// [R2] Bank-select bit set opens even latch, clear opens odd latch.
// [R3] Latch enables also need the high phase of the 8 ns delayed clock.
// [R4] Write latch closes before the system clock cycle ends.
// [R5] Five identical row strobes: four to memory, one to mux delay line.
// [R6] Row strobe asserts on valid instruction, data or general start.
// [R7] Row strobe holds until the current access kind's exit condition; the code also holds it past the exit while write_burst_pending is set.
// [R8] Instruction and data chip select asserts the cycle after row strobe.
// [R9] On writes only the bank picked by the select bit gets chip select.
// [R10] Write chip select also needs data ready in the previous cycle.
// [R11] Refresh chip select asserts in idle, before the row strobe.
// [R12] Address bits 13 to 22 pass through a transparent hold latch.
// [R13] Each latched bit carries a redundant input-and-output hold term.
// [R14] Address latch enable follows the delayed clock high phase.
// [R15] Address latch enable blocked in first instruction and data states.
// [R16] Address latch enable blocked in both precharge states.
// [R17] Registered outputs are flip-flops on ref_clk, others combinational.
// [R18] The bank-select bit is the even-bank counter low bit.
// [R19] Write enable rises in first second-data-state cycle, holds for write.
// [R20] Refresh counter is a free-running binary up-counter.
module interleaved_dram_strobe_latch_ctrl (
   input  wire logic                                          ref_clk,
   input  wire logic                                          rst,
   input  wire logic                                          even_bank_sel_bit,
   input  wire logic                                          delayed_sys_clock,
   input  wire logic                                          bus_invalid,
   input  wire logic                                          access_begin,
   input  wire logic                                          instr_access_begin,
   input  wire logic                                          data_access_begin,
   input  wire logic                                          instr_access_done,
   input  wire logic                                          data_access_done,
   input  wire logic                                          refresh_done,
   input  wire logic                                          write_burst_pending,
   input  wire logic                                          data_ready_ack,
   input  wire logic                                          read_cycle,
   input  wire logic                                          idle_state,
   input  wire logic                                          refresh_request,
   input  wire logic                                          instr_state_first,
   input  wire logic                                          data_state_first,
   input  wire logic                                          data_state_second,
   input  wire logic                                          precharge_state_one,
   input  wire logic                                          precharge_state_two,
   input  wire logic                                          data_burst_ack_int,
   input  wire logic [strobe_latch_pkg::ADDR_W-1:0]           cpu_addr,
   output logic                                               wr_latch_en_even,
   output logic                                               wr_latch_en_odd,
   output logic [strobe_latch_pkg::ROW_STROBE_COPIES-1:0]     row_strobe_out,
   output logic                                               mux_switch_strobe,
   output logic [strobe_latch_pkg::CS_COPIES-1:0]             chip_sel_even,
   output logic [strobe_latch_pkg::CS_COPIES-1:0]             chip_sel_odd,
   output logic                                               write_en_bank_even,
   output logic                                               write_en_bank_odd,
   output logic                                               addr_latch_en,
   output logic [strobe_latch_pkg::ADDR_W-1:0]                latched_addr,
   output logic                                               latched_addr_top_bit,
   output logic [strobe_latch_pkg::REF_W-1:0]                 refresh_count,
   output logic                                               refresh_count_bit_low
);
   import strobe_latch_pkg::*;

   // Row strobe copies and owning access kind
   logic [ROW_STROBE_COPIES-1:0] ras_r;
   logic [ROW_STROBE_COPIES-1:0] ras_nxt;
   access_kind_type              kind_r;
   access_kind_type              kind_nxt;

   // Chip selects
   logic [CS_COPIES-1:0]         cs_even_r;
   logic [CS_COPIES-1:0]         cs_even_nxt;
   logic [CS_COPIES-1:0]         cs_odd_r;
   logic [CS_COPIES-1:0]         cs_odd_nxt;

   // Write enables and data ready history
   logic                         we_r;
   logic                         we_nxt;
   logic                         data_ready_ack_prev_r;

   // Refresh counter
   logic [REF_W-1:0]             ref_r;
   logic [REF_W-1:0]             ref_nxt;

   // Decode wires
   wire                          ras_active;
   wire                          start_any;
   wire                          start_ok;
   wire                          exit_cur;
   wire                          ras_hold;
   wire                          ras_set;
   wire                          rd_wr_access;
   wire                          write_access;
   wire                          access_cs;
   wire                          write_cs_even;
   wire                          write_cs_odd;
   wire                          refresh_cs_pre;
   wire                          refresh_cs_hold;
   wire                          refresh_cs;
   wire                          bank_even_sel;
   wire                          bank_odd_sel;
   wire                          ale_block;
   wire                          refresh_start;
   logic                         exit_cur_c;

   // Bank-select bit is the even-bank counter low bit
   assign bank_even_sel = even_bank_sel_bit;                   // see [R18]
   assign bank_odd_sel  = ~even_bank_sel_bit;                  // see [R18]

   // Write-data latch enables
   // Select bit alternates each cycle, so each latch opens every other cycle;
   // the delayed clock hides the select bit's clock-to-output settle.
   assign wr_latch_en_even = bank_even_sel & delayed_sys_clock; // see [R1] [R2] [R3]
   // Delayed clock falls inside the cycle, closing the latch before the
   // processor moves write data.
   assign wr_latch_en_odd  = bank_odd_sel & delayed_sys_clock;  // see [R1] [R2] [R4]

   // Row strobe
   assign ras_active = ras_r[0];
   assign start_any  = access_begin | instr_access_begin | data_access_begin;
   assign start_ok   = ~bus_invalid & start_any;                // see [R6]
   assign ras_set    = ~ras_active & start_ok;                  // see [R6]

   always_comb begin
      unique case (kind_r)
         kind_idle:    exit_cur_c = 1'b1;
         kind_instr:   exit_cur_c = instr_access_done;
         kind_data:    exit_cur_c = data_access_done;
         kind_refresh: exit_cur_c = refresh_done;
      endcase
   end
   assign exit_cur = exit_cur_c;                                // see [R7]

   // A pending write burst keeps the row open past the exit
   assign ras_hold = ras_active & (~exit_cur | write_burst_pending); // see [R7]

   assign ras_nxt = {ROW_STROBE_COPIES{ras_set | ras_hold}};    // see [R5]

   // Access kind tracking; instruction wins over data, a general start alone is a refresh
   always_comb begin
      kind_nxt = kind_r;
      if (ras_set) begin
         if (instr_access_begin) begin
            kind_nxt = kind_instr;
         end else if (data_access_begin) begin
            kind_nxt = kind_data;
         end else begin
            kind_nxt = kind_refresh;
         end
      end else if (!ras_hold) begin
         kind_nxt = kind_idle;
      end
   end

   // Chip select
   assign rd_wr_access = ras_active & ((kind_r == kind_instr) | (kind_r == kind_data));
   assign write_access = ras_active & (kind_r == kind_data) & ~read_cycle;
   // Registered from the row strobe, so lands one cycle after it
   assign access_cs    = rd_wr_access & ~write_access & ras_hold; // see [R8]
   // Chip select is the real write strobe, so it must track the bank
   assign write_cs_even = write_access & ras_hold & bank_even_sel
                          & data_ready_ack_prev_r;                           // see [R9] [R10]
   assign write_cs_odd  = write_access & ras_hold & bank_odd_sel
                          & data_ready_ack_prev_r;                           // see [R9] [R10]
   // Column-before-row refresh: select first, in idle
   assign refresh_cs_pre  = idle_state & refresh_request & ~ras_active; // see [R11]
   // Keep select on as the refresh row strobe rises, else the refresh is lost
   assign refresh_start   = ras_set & ~instr_access_begin & ~data_access_begin;
   assign refresh_cs_hold = (refresh_start | (ras_active & (kind_r == kind_refresh)))
                            & ~refresh_done;                       // see [R11]
   assign refresh_cs      = refresh_cs_pre | refresh_cs_hold;     // see [R11]

   assign cs_even_nxt = {CS_COPIES{access_cs | write_cs_even | refresh_cs}};
   assign cs_odd_nxt  = {CS_COPIES{access_cs | write_cs_odd | refresh_cs}};

   // Write enable, shared by both banks
   assign we_nxt = data_burst_ack_int & ~read_cycle
                   & (data_state_second | we_r);                   // see [R19]

   // Refresh counter: bit i toggles when every lower bit is set
   always_comb begin
      logic carry;
      carry   = 1'b1;
      ref_nxt = ref_r;
      for (int i = 0; i < REF_W; i++) begin
         ref_nxt[i] = ref_r[i] ^ carry;                            // see [R20]
         carry      = carry & ref_r[i];
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ras_r       <= ROW_STROBE_RESET;
         kind_r      <= kind_idle;
         cs_even_r   <= CS_RESET;
         cs_odd_r    <= CS_RESET;
         we_r        <= 1'b0;
         data_ready_ack_prev_r <= 1'b0;
         ref_r       <= REF_RESET;
      end else begin
         ras_r       <= ras_nxt;                                   // see [R17]
         kind_r      <= kind_nxt;
         cs_even_r   <= cs_even_nxt;
         cs_odd_r    <= cs_odd_nxt;
         we_r        <= we_nxt;                                    // see [R17]
         data_ready_ack_prev_r <= data_ready_ack;                            // see [R10]
         ref_r       <= ref_nxt;                                   // see [R20]
      end
   end

   assign row_strobe_out        = ras_r;                           // see [R5]
   assign mux_switch_strobe     = ras_r[ROW_STROBE_MUX];           // see [R5]
   assign chip_sel_even         = cs_even_r;
   assign chip_sel_odd          = cs_odd_r;
   assign write_en_bank_even    = we_r;
   assign write_en_bank_odd     = we_r;
   assign refresh_count         = ref_r;
   assign refresh_count_bit_low = ref_r[0];

   // Address latch enable
   // Holding through precharge keeps a resumed same-kind address intact.
   assign ale_block     = instr_state_first | data_state_first     // see [R15]
                          | precharge_state_one | precharge_state_two; // see [R16]
   assign addr_latch_en = ~ale_block & delayed_sys_clock;           // see [R14] [R17]

   addr_hold_latch u_addr_latch (
      .rst      (rst),
      .latch_en (addr_latch_en),
      .addr_in  (cpu_addr),
      .addr_out (latched_addr)
   );

   assign latched_addr_top_bit = latched_addr[ADDR_W-1];

endmodule : interleaved_dram_strobe_latch_ctrl

// ---- clk_delay_line_model.sv ----
`timescale 1ns/1ns
module clk_delay_line_model
   import strobe_latch_pkg::*;
(
   input  wire logic ref_clk,
   output logic      delayed_sys_clock
);
   initial delayed_sys_clock = 1'b0;
   // Transport delay, so no edge of the copy is swallowed
   always @(ref_clk) delayed_sys_clock <= #(CLK_DELAY_NS) ref_clk;
endmodule : clk_delay_line_model

// ---- strobe_latch_chk.sv ----
`timescale 1ns/1ns
module strobe_latch_chk
   import strobe_latch_pkg::*;
(
   input wire logic                         ref_clk,
   input wire logic                         rst,
   input wire logic                         even_bank_sel_bit,
   input wire logic                         delayed_sys_clock,
   input wire logic                         bus_invalid,
   input wire logic                         access_begin,
   input wire logic                         instr_access_begin,
   input wire logic                         data_access_begin,
   input wire logic                         instr_access_done,
   input wire logic                         data_access_done,
   input wire logic                         refresh_done,
   input wire logic                         read_cycle,
   input wire logic                         idle_state,
   input wire logic                         refresh_request,
   input wire logic                         instr_state_first,
   input wire logic                         data_state_first,
   input wire logic                         precharge_state_one,
   input wire logic                         precharge_state_two,
   input wire logic [ADDR_W-1:0]            cpu_addr,
   input wire logic                         wr_latch_en_even,
   input wire logic                         wr_latch_en_odd,
   input wire logic [ROW_STROBE_COPIES-1:0] row_strobe_out,
   input wire logic                         mux_switch_strobe,
   input wire logic [CS_COPIES-1:0]         chip_sel_even,
   input wire logic [CS_COPIES-1:0]         chip_sel_odd,
   input wire logic                         addr_latch_en,
   input wire logic [ADDR_W-1:0]            latched_addr,
   input wire logic [REF_W-1:0]             refresh_count
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Delayed copy is low at every rising edge, so window terms are seen on the falling one
   property p_wr_latch;
      @(negedge ref_clk) disable iff (rst)
      wr_latch_en_even == (even_bank_sel_bit && delayed_sys_clock) &&
      wr_latch_en_odd == (!even_bank_sel_bit && delayed_sys_clock);
   endproperty
   a_wr_latch: assert property (p_wr_latch) else $error("write latch wrong");
   property p_ale;
      @(negedge ref_clk) disable iff (rst)
      addr_latch_en == (delayed_sys_clock && !(instr_state_first || data_state_first ||
                        precharge_state_one || precharge_state_two));
   endproperty
   a_ale: assert property (p_ale) else $error("address enable wrong");
   property p_latch;
      @(negedge ref_clk) disable iff (rst) addr_latch_en |-> latched_addr == cpu_addr;
   endproperty
   a_latch: assert property (p_latch) else $error("address latch not transparent");
   property p_rows;
      (row_strobe_out == '0 || row_strobe_out == '1) && mux_switch_strobe == row_strobe_out[0];
   endproperty
   a_rows: assert property (p_rows) else $error("row strobe copies differ");
   property p_row_start;
      !row_strobe_out[0] && !bus_invalid && instr_access_begin |=> row_strobe_out == '1;
   endproperty
   a_row_start: assert property (p_row_start) else $error("row strobe did not start");
   property p_row_hold;
      row_strobe_out[0] && !instr_access_done && !data_access_done && !refresh_done
      |=> row_strobe_out[0];
   endproperty
   a_row_hold: assert property (p_row_hold) else $error("row strobe dropped early");
   property p_cs_after;
      !row_strobe_out[0] && !bus_invalid && instr_access_begin ##1 read_cycle && !instr_access_done
      |=> chip_sel_even == CS_ALL && chip_sel_odd == CS_ALL;
   endproperty
   a_cs_after: assert property (p_cs_after) else $error("chip select late");
   property p_cs_refresh;
      idle_state && refresh_request && !row_strobe_out[0]
      |=> chip_sel_even == CS_ALL && chip_sel_odd == CS_ALL;
   endproperty
   a_cs_refresh: assert property (p_cs_refresh) else $error("refresh select missing");
   property p_cs_cbr;
      chip_sel_even == CS_ALL && !row_strobe_out[0] && !bus_invalid && access_begin &&
      !instr_access_begin && !data_access_begin && !refresh_done
      |=> chip_sel_even == CS_ALL && row_strobe_out == '1;
   endproperty
   a_cs_cbr: assert property (p_cs_cbr) else $error("refresh select dropped");
   property p_count;
      !$past(rst) |-> refresh_count == $past(refresh_count) + 9'h001;
   endproperty
   a_count: assert property (p_count) else $error("refresh counter did not step");
   c_row_rise: cover property ($rose(row_strobe_out[0]));
   c_refresh_cs: cover property (chip_sel_even == CS_ALL && row_strobe_out == ROW_STROBE_RESET);
   c_bank_write: cover property (chip_sel_even == CS_ALL && chip_sel_odd == CS_RESET);
endmodule : strobe_latch_chk
bind interleaved_dram_strobe_latch_ctrl strobe_latch_chk u_strobe_latch_chk (.*);

// ---- test_interleaved_dram_strobe_latch_ctrl.sv ----
`timescale 1ns/1ns
module test_interleaved_dram_strobe_latch_ctrl;
   import strobe_latch_pkg::*;
   logic ref_clk, rst, even_bank_sel_bit, delayed_sys_clock, bus_invalid, access_begin;
   logic instr_access_begin, data_access_begin, instr_access_done, data_access_done;
   logic refresh_done, write_burst_pending, data_ready_ack, read_cycle, idle_state;
   logic refresh_request, instr_state_first, data_state_first, data_state_second;
   logic precharge_state_one, precharge_state_two, data_burst_ack_int, mux_switch_strobe;
   logic wr_latch_en_even, wr_latch_en_odd, write_en_bank_even, write_en_bank_odd;
   logic addr_latch_en, latched_addr_top_bit, refresh_count_bit_low;
   logic [ADDR_W-1:0]            cpu_addr, latched_addr;
   logic [ROW_STROBE_COPIES-1:0] row_strobe_out;
   logic [CS_COPIES-1:0]         chip_sel_even, chip_sel_odd;
   logic [REF_W-1:0]             refresh_count;
   int                           fail_count, checks, cycles;
   interleaved_dram_strobe_latch_ctrl u_interleaved_dram_strobe_latch_ctrl (.*);
   clk_delay_line_model u_clk_delay_line_model (.ref_clk(ref_clk),
                                                .delayed_sys_clock(delayed_sys_clock));
   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   // Also the expected refresh count; ceiling is far above the ~550 cycles used
   always @(posedge ref_clk) begin
      cycles <= rst ? 0 : cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         finish_test();
      end
   end
   task tick;
      @(posedge ref_clk);
   endtask : tick
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task finish_test;
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {even_bank_sel_bit, bus_invalid, access_begin, instr_access_begin, data_access_begin,
       instr_access_done, data_access_done, refresh_done, write_burst_pending, data_ready_ack,
       idle_state, refresh_request, instr_state_first, data_state_first, data_state_second,
       precharge_state_one, precharge_state_two, data_burst_ack_int} = '0;
      read_cycle = 1'b1;
      cpu_addr = 10'h000;
      fail_count = 0;
      checks = 0;
      cycles = 0;
      repeat (3) tick;
      rst <= 1'b0;
      #12 chk(16'({row_strobe_out, refresh_count}), 16'h0000);
      tick;
      instr_access_begin <= 1'b1;
      tick;
      instr_access_begin <= 1'b0;
      #12 chk(16'({row_strobe_out, mux_switch_strobe}), 16'h003f);
      tick;
      instr_access_done <= 1'b1;
      write_burst_pending <= 1'b1;
      #12 chk(16'({row_strobe_out, chip_sel_even, chip_sel_odd}), 16'h01ff);
      tick;
      write_burst_pending <= 1'b0;
      #12 chk(16'(row_strobe_out), 16'h001f);
      tick;
      instr_access_done <= 1'b0;
      bus_invalid <= 1'b1;
      instr_access_begin <= 1'b1;
      #12 chk(16'({row_strobe_out, chip_sel_even, chip_sel_odd}), 16'h0000);
      tick;
      bus_invalid <= 1'b0;
      instr_access_begin <= 1'b0;
      #12 chk(16'(row_strobe_out), 16'h0000);
      // Bank write: select set, data accepted the cycle before
      tick;
      data_access_begin <= 1'b1;
      read_cycle <= 1'b0;
      even_bank_sel_bit <= 1'b1;
      data_ready_ack <= 1'b1;
      tick;
      data_access_begin <= 1'b0;
      data_state_second <= 1'b1;
      data_burst_ack_int <= 1'b1;
      #12 chk(16'({wr_latch_en_even, wr_latch_en_odd, write_en_bank_even, write_en_bank_odd}),
              16'h0008);
      tick;
      even_bank_sel_bit <= 1'b0;
      data_ready_ack <= 1'b0;
      data_state_second <= 1'b0;
      #12 chk(16'({chip_sel_even, chip_sel_odd, write_en_bank_even, write_en_bank_odd}),
              16'h0033);
      tick;
      #12 chk(16'({wr_latch_en_even, wr_latch_en_odd, chip_sel_even, chip_sel_odd,
                   write_en_bank_even, write_en_bank_odd}), 16'h004f);
      #20 chk(16'({wr_latch_en_even, wr_latch_en_odd}), 16'h0000);
      tick;
      data_access_done <= 1'b1;
      data_burst_ack_int <= 1'b0;
      #12 chk(16'({chip_sel_even, chip_sel_odd}), 16'h0000);
      tick;
      data_access_done <= 1'b0;
      read_cycle <= 1'b1;
      tick;
      idle_state <= 1'b1;
      refresh_request <= 1'b1;
      tick;
      idle_state <= 1'b0;
      refresh_request <= 1'b0;
      access_begin <= 1'b1;
      #12 chk(16'({row_strobe_out, chip_sel_even, chip_sel_odd}), 16'h000f);
      tick;
      access_begin <= 1'b0;
      refresh_done <= 1'b1;
      #12 chk(16'({row_strobe_out, chip_sel_even, chip_sel_odd}), 16'h01ff);
      tick;
      refresh_done <= 1'b0;
      #12 chk(16'({row_strobe_out, chip_sel_even, chip_sel_odd}), 16'h0000);
      // Data read: both banks selected the cycle after the row strobe
      tick;
      data_access_begin <= 1'b1;
      tick;
      data_access_begin <= 1'b0;
      tick;
      data_access_done <= 1'b1;
      #12 chk(16'({row_strobe_out, chip_sel_even, chip_sel_odd}), 16'h01ff);
      tick;
      data_access_done <= 1'b0;
      tick;
      cpu_addr <= 10'h155;
      #12 chk(16'({addr_latch_en, latched_addr_top_bit, latched_addr}),
              16'h0955);
      for (int i = 0; i < 4; i++) begin
         tick;
         {instr_state_first, data_state_first, precharge_state_one, precharge_state_two} <=
            4'h8 >> i;
         cpu_addr <= 10'h2aa;
         #12 chk(16'({addr_latch_en, latched_addr_top_bit, latched_addr}),
                 16'h0155);
      end
      tick;
      {instr_state_first, data_state_first, precharge_state_one, precharge_state_two} <= 4'h0;
      #12 chk(16'({addr_latch_en, latched_addr_top_bit, latched_addr}),
              16'h0eaa);
      repeat (520) tick;
      #12 chk(16'({refresh_count_bit_low, refresh_count}),
              16'({cycles[0], cycles[REF_W-1:0]}));
      finish_test();
   end
endmodule : test_interleaved_dram_strobe_latch_ctrl
